// ===== smi_defs.svh
// constants of the step/direction microstepping indexer
`ifndef SMI_DEFS_SVH
`define SMI_DEFS_SVH

// ----------------------------------------------------------------
// position counter
// ----------------------------------------------------------------
`define SMI_POS_W        7
`define SMI_HOME_POS     7'h10
`define SMI_FULL_OFFSET  7'h10
`define SMI_ZERO_POS     7'h00
`define SMI_QUARTER      6'h20

// ----------------------------------------------------------------
// step size exponents, position units per step
// ----------------------------------------------------------------
`define SMI_SHIFT_FULL   3'h5
`define SMI_SHIFT_HALF   3'h4
`define SMI_SHIFT_QUART  3'h3
`define SMI_SHIFT_8TH    3'h2
`define SMI_SHIFT_16TH   3'h1
`define SMI_SHIFT_32ND   3'h0

// ----------------------------------------------------------------
// reset values of outputs
// ----------------------------------------------------------------
`define SMI_HOME_PCT     8'sh47
`define SMI_PCT_W        8

`endif

// ===== smi_pkg.sv
// types of the step/direction microstepping indexer
package smi_pkg;

   // ----------------------------------------------------------------
   // pin front end
   // ----------------------------------------------------------------
   typedef struct packed {
      logic step_in;
      logic dir;
      logic output_disable_n;
      logic uvlo_active;
      logic sleep_n;
      logic mode_select_0_hi;
      logic mode_select_0_lo;
      logic mode_select_1_hi;
      logic mode_select_1_lo;
   } smi_pins_t;

   typedef enum logic [1:0] {
      smi_lvl_low,
      smi_lvl_open,
      smi_lvl_high
   } smi_level_t;

   // ----------------------------------------------------------------
   // decoded step mode
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] shift;
      logic       both_edges;
   } smi_mode_t;

   // ----------------------------------------------------------------
   // winding outputs
   // ----------------------------------------------------------------
   typedef struct packed {
      logic signed [7:0] current_a;
      logic signed [7:0] current_b;
   } smi_target_t;

   typedef struct packed {
      logic a_out_pos;
      logic a_out_neg;
      logic b_out_pos;
      logic b_out_neg;
   } smi_drive_t;

endpackage : smi_pkg

// ===== smi_indexer.sv
// microstepping indexer driven by step and direction pins
//
// Overview of operation
// - qualifying step edge advances one step of the selected resolution
// - disable pin stops bridge only, indexer keeps tracking
// - mode_select_1 low: full, half, quarter; rising
// - mode_select_1 open: eighth step, rising or both; sixteenth step rising
// - sixteenth step, rising or both edges
// - mode_select_1 high: sixteenth step on both edges, thirty-second step rising or both
// - mode pins decode low, high or released
// - first step after a mode change moves to next valid position
// - home 45 degrees at reset, uvlo, sleep exit
// - direction high forward, low reverse
// - positive target drives positive output high
// - targets are cosine A, sine B percent
// - coarser modes visit sparser entries, full offset
`timescale 1ns/1ps
`include "smi_defs.svh"

module smi_indexer #(
   parameter int POS_W = `SMI_POS_W
) (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst,
   // pins from the controller, asynchronous
   input  wire smi_pkg::smi_pins_t  pins,
   // winding current targets in percent
   output      smi_pkg::smi_target_t target,
   // bridge drive polarity
   output      smi_pkg::smi_drive_t drive,
   output      logic                bridge_on,
   // indexer state
   output      logic [6:0]          position,
   output      smi_pkg::smi_mode_t  mode
);
   import smi_pkg::*;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (POS_W != `SMI_POS_W)
   begin : g_bad_width
      $error("position width must be seven bits");
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   smi_pins_t   pins_s1;
   smi_pins_t   pins_s2;
   logic        step_d;
   smi_pins_t   next_pins_s1;
   smi_pins_t   next_pins_s2;
   logic        next_step_d;
   logic [6:0]  next_position;
   smi_target_t next_target;
   smi_drive_t  next_drive;
   logic        next_bridge_on;
   smi_mode_t   next_mode;
   smi_level_t  lvl0;
   smi_level_t  lvl1;
   logic        rise;
   logic        fall;
   logic        advance;
   logic        hold_home;
   logic [6:0]  size;
   logic [6:0]  offset;
   logic [6:0]  base;
   logic [6:0]  mask;
   logic [6:0]  fwd_pos;
   logic [6:0]  rev_pos;

   // ----------------------------------------------------------------
   // quarter wave of cosine, percent, index 0 to 32
   // ----------------------------------------------------------------
   function automatic logic [6:0] cos_mag(input logic [5:0] k);
      logic [6:0] m;
      m = 7'h00;
      case (k)
         6'h00, 6'h01, 6'h02: m = 7'h64;
         6'h03: m = 7'h63;
         6'h04: m = 7'h62;
         6'h05: m = 7'h61;
         6'h06: m = 7'h60;
         6'h07: m = 7'h5e;
         6'h08: m = 7'h5c;
         6'h09: m = 7'h5a;
         6'h0a: m = 7'h58;
         6'h0b: m = 7'h56;
         6'h0c: m = 7'h53;
         6'h0d: m = 7'h50;
         6'h0e: m = 7'h4d;
         6'h0f: m = 7'h4a;
         6'h10: m = 7'h47;
         6'h11: m = 7'h43;
         6'h12: m = 7'h3f;
         6'h13: m = 7'h3c;
         6'h14: m = 7'h38;
         6'h15: m = 7'h33;
         6'h16: m = 7'h2f;
         6'h17: m = 7'h2b;
         6'h18: m = 7'h26;
         6'h19: m = 7'h22;
         6'h1a: m = 7'h1d;
         6'h1b: m = 7'h18;
         6'h1c: m = 7'h14;
         6'h1d: m = 7'h0f;
         6'h1e: m = 7'h0a;
         6'h1f: m = 7'h05;
         default: m = 7'h00;
      endcase
      return m;
   endfunction : cos_mag

   function automatic logic signed [7:0] pct(input logic [6:0] m,
                                             input logic neg);
      logic signed [7:0] v;
      v = signed'({1'b0, m});
      return neg ? -v : v;
   endfunction : pct

   // ----------------------------------------------------------------
   // tri-level and mode decode
   // ----------------------------------------------------------------
   function automatic smi_level_t tri_decode(input logic hi,
                                             input logic lo);
      smi_level_t l;
      l = smi_lvl_open;
      if (hi && !lo)
      begin
         l = smi_lvl_high;
      end
      else if (lo && !hi)
      begin
         l = smi_lvl_low;
      end
      return l;
   endfunction : tri_decode

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [4:0] r;
      logic [5:0] rc;
      r  = 5'h00;
      rc = 6'h00;
      next_pins_s1 = pins;
      next_pins_s2 = pins_s1;
      next_step_d  = pins_s2.step_in;

      lvl0 = tri_decode(pins_s2.mode_select_0_hi,
                        pins_s2.mode_select_0_lo);
      lvl1 = tri_decode(pins_s2.mode_select_1_hi,
                        pins_s2.mode_select_1_lo);
      next_mode = '{shift: `SMI_SHIFT_FULL, both_edges: 1'b0};
      case (lvl1)
         smi_lvl_low:
         begin
            case (lvl0)
               smi_lvl_low:  next_mode.shift = `SMI_SHIFT_FULL;
               smi_lvl_open: next_mode.shift = `SMI_SHIFT_HALF;
               default:      next_mode.shift = `SMI_SHIFT_QUART;
            endcase
         end
         smi_lvl_open:
         begin
            case (lvl0)
               smi_lvl_low:
               begin
                  next_mode.shift = `SMI_SHIFT_8TH;
               end
               smi_lvl_open:
               begin
                  next_mode.shift = `SMI_SHIFT_8TH;
                  next_mode.both_edges = 1'b1;
               end
               default:
               begin
                  next_mode.shift = `SMI_SHIFT_16TH;
               end
            endcase
         end
         default:
         begin
            case (lvl0)
               smi_lvl_low:
               begin
                  next_mode.shift = `SMI_SHIFT_16TH;
                  next_mode.both_edges = 1'b1;
               end
               smi_lvl_open:
               begin
                  next_mode.shift = `SMI_SHIFT_32ND;
               end
               default:
               begin
                  next_mode.shift = `SMI_SHIFT_32ND;
                  next_mode.both_edges = 1'b1;
               end
            endcase
         end
      endcase

      // step edge qualification
      rise    = pins_s2.step_in && !step_d;
      fall    = !pins_s2.step_in && step_d;
      advance = rise || (fall && next_mode.both_edges);

      // next valid position for the selected resolution
      size    = 7'h01 << next_mode.shift;
      offset  = (next_mode.shift == `SMI_SHIFT_FULL) ?
                `SMI_FULL_OFFSET : `SMI_ZERO_POS;
      base    = position - offset;
      mask    = ~(size - 7'h01);
      fwd_pos = ((base & mask) + size) + offset;
      rev_pos = (((base & ~mask) == `SMI_ZERO_POS) ?
                 base - size : base & mask) + offset;

      hold_home = pins_s2.uvlo_active || !pins_s2.sleep_n;
      next_position = position;
      if (hold_home)
      begin
         next_position = `SMI_HOME_POS;
      end
      else if (advance)
      begin
         next_position = pins_s2.dir ? fwd_pos : rev_pos;
      end

      // cosine on A, sine on B
      r  = next_position[4:0];
      rc = `SMI_QUARTER - {1'b0, r};
      case (next_position[6:5])
         2'h0:
         begin
            next_target.current_a = pct(cos_mag({1'b0, r}), 1'b0);
            next_target.current_b = pct(cos_mag(rc), 1'b0);
         end
         2'h1:
         begin
            next_target.current_a = pct(cos_mag(rc), 1'b1);
            next_target.current_b = pct(cos_mag({1'b0, r}), 1'b0);
         end
         2'h2:
         begin
            next_target.current_a = pct(cos_mag({1'b0, r}), 1'b1);
            next_target.current_b = pct(cos_mag(rc), 1'b1);
         end
         default:
         begin
            next_target.current_a = pct(cos_mag(rc), 1'b0);
            next_target.current_b = pct(cos_mag({1'b0, r}), 1'b1);
         end
      endcase

      // bridge polarity and output stage
      next_bridge_on = !pins_s2.output_disable_n && !hold_home;
      next_drive.a_out_pos = next_bridge_on &&
                             (next_target.current_a > 8'sh00);
      next_drive.a_out_neg = next_bridge_on &&
                             (next_target.current_a < 8'sh00);
      next_drive.b_out_pos = next_bridge_on &&
                             (next_target.current_b > 8'sh00);
      next_drive.b_out_neg = next_bridge_on &&
                             (next_target.current_b < 8'sh00);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pins_s1   <= '0;
         pins_s2   <= '0;
         step_d    <= 1'b0;
         position  <= `SMI_HOME_POS;
         target    <= '{current_a: `SMI_HOME_PCT,
                        current_b: `SMI_HOME_PCT};
         drive     <= '0;
         bridge_on <= 1'b0;
         mode      <= '{shift: `SMI_SHIFT_FULL, both_edges: 1'b0};
      end
      else
      begin
         pins_s1   <= next_pins_s1;
         pins_s2   <= next_pins_s2;
         step_d    <= next_step_d;
         position  <= next_position;
         target    <= next_target;
         drive     <= next_drive;
         bridge_on <= next_bridge_on;
         mode      <= next_mode;
      end
   end

endmodule : smi_indexer

// ===== smi_checker.sv
// assertions on the ports of the microstepping indexer
`timescale 1ns/1ps
module smi_checker (
   // clock and reset
   input wire logic                 core_clk,
   input wire logic                 rst,
   // watched ports
   input wire smi_pkg::smi_pins_t   pins,
   input wire smi_pkg::smi_target_t target,
   input wire smi_pkg::smi_drive_t  drive,
   input wire logic                 bridge_on,
   input wire logic [6:0]           position,
   input wire smi_pkg::smi_mode_t   mode
);
   import smi_pkg::*;
   // ----
   // properties
   // ----
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_rise;
      $rose(pins.step_in) && pins.sleep_n && !pins.uvlo_active;
   endsequence
   AST_HOME: assert property ($fell(rst) |-> position == 7'h10
      && target == 16'h4747) else $error("home not loaded");
   AST_SLEEP: assert property (!pins.sleep_n [*4] |->
      position == 7'h10 && !bridge_on) else $error("sleep not home");
   AST_DISABLE: assert property (pins.output_disable_n [*4] |->
      !bridge_on && drive == 4'h0) else $error("bridge still on");
   AST_POL: assert property (drive == {
      bridge_on && target.current_a > 8'sh00,
      bridge_on && target.current_a < 8'sh00,
      bridge_on && target.current_b > 8'sh00,
      bridge_on && target.current_b < 8'sh00}) else $error("bad polarity");
   AST_ADV: assert property (s_rise |-> ##[2:4] !$stable(position))
      else $error("rising edge lost");
   AST_DIR: assert property (s_rise ##0 mode.shift == 3'h0 |-> ##3
      position == $past(position, 3) + ($past(pins.dir, 3) ? 7'h01 : 7'h7f))
      else $error("wrong step sense");
   AST_FALL: assert property ($fell(pins.step_in) && !mode.both_edges
      && pins.sleep_n && !pins.uvlo_active |=> $stable(position) [*4])
      else $error("falling edge moved");
   AST_FULL: assert property (mode.shift == 3'h5 [*4] ##0
      !$stable(position) |-> position[4:0] == 5'h10)
      else $error("full step off grid");
   AST_TABLE: assert property (position == 7'h10 |->
      target == 16'h4747) else $error("home currents wrong");
endmodule : smi_checker

bind smi_indexer smi_checker u_chk (.core_clk(core_clk), .rst(rst),
   .pins(pins), .target(target), .drive(drive), .bridge_on(bridge_on),
   .position(position), .mode(mode));

// ===== smi_ctrl_model.sv
// controller model driving step, direction and tri-level mode pins
`timescale 1ns/1ps
module smi_ctrl_model (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst,
   // commands from the bench
   input  wire logic                tgl,
   input  wire logic                dir,
   input  wire logic                dis,
   input  wire logic                uvlo,
   input  wire logic                sleep_n,
   input  wire smi_pkg::smi_level_t lvl_0,
   input  wire smi_pkg::smi_level_t lvl_1,
   // pins to the indexer
   output      smi_pkg::smi_pins_t  pins
);
   import smi_pkg::*;
   // ----
   // pin drive
   // ----
   logic step_lvl;
   // step idles low through reset so no false edge follows it
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         step_lvl <= 1'b0;
      end
      else if (tgl)
      begin
         step_lvl <= !step_lvl;
      end
   end
   // released pin leaves both comparators low
   always_comb
   begin
      pins.step_in          = step_lvl;
      pins.dir              = dir;
      pins.output_disable_n = dis;
      pins.uvlo_active      = uvlo;
      pins.sleep_n          = sleep_n;
      pins.mode_select_0_hi = (lvl_0 == smi_lvl_high);
      pins.mode_select_0_lo = (lvl_0 == smi_lvl_low);
      pins.mode_select_1_hi = (lvl_1 == smi_lvl_high);
      pins.mode_select_1_lo = (lvl_1 == smi_lvl_low);
   end
endmodule : smi_ctrl_model

// ===== smi_testbench.sv
// self-checking bench of the microstepping indexer
`timescale 1ns/1ps
module testbench;
   import smi_pkg::*;
   logic                   core_clk, rst, tgl, dir, dis, uvlo, slp_n;
   smi_level_t             l0, l1;
   smi_pins_t              pins;
   smi_target_t            target;
   smi_drive_t             drive;
   logic                   bridge_on, sl;
   logic [6:0]             position, ep;
   smi_mode_t              mode;
   int                     n_fail, checks, mi;
   logic [31:0]            rs;
   localparam logic [26:0] SHX = 27'h4a4e5;
   localparam logic [8:0]  BEX = 9'h150;
   byte ct[33] = '{100, 100, 100, 99, 98, 97, 96, 94, 92, 90, 88, 86, 83,
      80, 77, 74, 71, 67, 63, 60, 56, 51, 47, 43, 38, 34, 29, 24, 20, 15,
      10, 5, 0};
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = !core_clk;
   end
   smi_ctrl_model u_ctl (.core_clk(core_clk), .rst(rst), .tgl(tgl), .dir(dir),
      .dis(dis), .uvlo(uvlo), .sleep_n(slp_n), .lvl_0(l0), .lvl_1(l1),
      .pins(pins));
   smi_indexer u_dut (.core_clk(core_clk), .rst(rst), .pins(pins),
      .target(target), .drive(drive), .bridge_on(bridge_on),
      .position(position), .mode(mode));
   // ----
   // expectation helpers
   // ----
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction : xs
   function automatic logic signed [7:0] cs(input logic [6:0] p);
      case (p[6:5])
         2'h0: cs = ct[p[4:0]];
         2'h1: cs = -ct[6'h20 - p[4:0]];
         2'h2: cs = -ct[p[4:0]];
         default: cs = ct[6'h20 - p[4:0]];
      endcase
   endfunction : cs
   function automatic logic [6:0] nxt(input logic [6:0] p,
      input logic [2:0] sh, input logic fw);
      logic [6:0] o, b, z, f;
      o = (sh == 3'h5) ? 7'h10 : 7'h00;
      b = p - o;
      z = 7'h01 << sh;
      f = b & ~(z - 7'h01);
      nxt = (fw ? f + z : (b == f ? b - z : f)) + o;
   endfunction : nxt
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   task automatic md(input int i);
      mi = i;
      l1 <= smi_level_t'(2'(i / 3));
      l0 <= smi_level_t'(2'(i % 3));
      cyc(6);
      chk(mode === {SHX[3*i +: 3], BEX[i]}, "mode");
   endtask : md
   task automatic stp(input logic fw);
      logic signed [7:0] a, b;
      logic              on;
      logic [3:0]        ed;
      dir <= fw;
      cyc(4);
      tgl <= 1'b1;
      cyc(1);
      tgl <= 1'b0;
      sl = !sl;
      if (sl || BEX[mi])
         ep = nxt(ep, SHX[3*mi +: 3], fw);
      cyc(6);
      a = cs(ep);
      b = cs(ep - 7'h20);
      on = !dis;
      ed = {on && a > 0, on && a < 0, on && b > 0, on && b < 0};
      chk(position === ep, "position");
      chk(target === {a, b}, "target");
      chk(bridge_on === on, "bridge");
      chk(drive === ed, "drive");
   endtask : stp
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // ----
   // main sequence
   // ----
   initial
   begin
      {rst, tgl, dir, dis, uvlo, slp_n} = 6'h21;
      l0 = smi_lvl_low;
      l1 = smi_lvl_low;
      {n_fail, checks, mi} = '0;
      {rs, ep, sl} = {32'h16, 7'h10, 1'b0};
      cyc(16);
      rst <= 1'b0;
      cyc(6);
      chk(position === 7'h10 && target === 16'h4747, "home");
      for (int i = 0; i < 9; i++)
         md(i);
      md(0);
      for (int i = 0; i < 16; i++)
         stp(i < 8);
      $display("test modes and full step done");
      for (int i = 0; i < 60; i++)
      begin
         rs = xs(rs);
         dis <= rs[8];
         md(int'(rs[7:0] % 8'h09));
         stp(rs[9]);
      end
      $display("test random stepping done");
      slp_n <= 1'b0;
      cyc(6);
      chk(position === 7'h10 && bridge_on === 1'b0, "sleep");
      slp_n <= 1'b1;
      ep = 7'h10;
      md(8);
      for (int i = 0; i < 20; i++)
         stp(1'b0);
      uvlo <= 1'b1;
      cyc(6);
      chk(position === 7'h10 && bridge_on === 1'b0, "uvlo hold");
      uvlo <= 1'b0;
      cyc(6);
      chk(position === 7'h10, "uvlo exit");
      $display("test sleep and undervoltage done");
      end_of_test();
   end
   initial
   begin
      cyc(50000);
      n_fail++;
      end_of_test();
   end
endmodule : testbench
